// ===== src/fbo_regs.vh
/*
 header of constants for the frame buffer overflow supervisor: register
 offsets, field positions, reset values and encodings.
 assumes inclusion by bare name from the design files.
*/
`ifndef FBO_REGS_VH
`define FBO_REGS_VH

`define ADDR_OCCUPANCY 12'h000
`define ADDR_STICKY_OVF 12'h004
`define ADDR_RELEASE_LVL 12'h008
`define ADDR_IMMED_LVL 12'h00c
`define ADDR_ALIGNED_LVL 12'h010
`define ADDR_EVENT_FILTER 12'h014
`define ADDR_STATE 12'h018

// thresholds held in half-percent units, 0..200
`define RST_RELEASE_LVL 8'd100
`define RST_IMMED_LVL 8'd199
`define RST_ALIGNED_LVL 8'd160
`define HALF_PCT_MAX 8'd200
`define PCT_FULL 8'd100

// event filter codes; bit0 truncated, bit1 dropped, bit2 good
`define FILT_TRUNC 3'h1
`define FILT_DROP 3'h2
`define FILT_TRUNC_OR_DROP 3'h3
`define FILT_GOOD 3'h4
`define FILT_TRUNC_OR_GOOD 3'h5
`define FILT_DROP_OR_GOOD 3'h6
`define FILT_ALL 3'h7
`define RST_EVENT_FILTER 3'h3
`define FILT_TRUNC_BIT 0
`define FILT_DROP_BIT 1
`define FILT_GOOD_BIT 2

// status mask bits inside the 16-bit mask field of the record
`define MASK_TRUNC_BIT 0
`define MASK_DROP_BIT 1
`define MASK_GOOD_BIT 2
`define REC_ID_LSB 0
`define REC_ID_MSB 15
`define REC_MASK_LSB 32
`define REC_MASK_MSB 47

`endif

// ===== src/fill_percent.v
/*
 converts buffer word occupancy to whole percent and half-percent units.
 assumes a buffer of 2**aw words and a count from 0 to 2**aw inclusive.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fbo_regs.vh"

module fill_percent #(
  parameter AW = 10
) (
  input wire [AW:0] count,
  output wire [7:0] whole_pct,
  output wire [7:0] half_pct
);
  // exact floor by multiply and shift; buffer depth is a power of two
  wire [AW+8:0] scaled_half;
  wire [AW+8:0] scaled_whole;
  assign scaled_half = count * `HALF_PCT_MAX;
  assign scaled_whole = count * `PCT_FULL;
  assign half_pct = scaled_half[AW+7:AW];
  assign whole_pct = scaled_whole[AW+7:AW];
endmodule // fill_percent

`default_nettype wire

// ===== src/frame_buffer_overflow_ctrl.v
/*
 frame buffer overflow supervisor with an apb register slave, a 1024-word
 pixel buffer of flip-flops, threshold based overflow state and per-frame
 event records. assumes the camera stream and the dma sink share pclk and
 that cam_sof and cam_eof each arrive as one-cycle pulses, eof not before
 sof. cam_valid data is taken only between them.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fbo_regs.vh"

module frame_buffer_overflow_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire cam_sof,
  input wire cam_eof,
  input wire [15:0] cam_frame_id,
  input wire cam_valid,
  input wire [31:0] cam_data,
  output wire cam_ready,
  output wire dma_valid,
  output reg [31:0] dma_data,
  output reg dma_last,
  output reg dma_truncated,
  input wire dma_ready,
  output reg event_valid,
  output reg [63:0] event_record
);
  localparam AW = 10;
  localparam DEPTH = 1024;

  // occupancy, tagged words: data, last flag, truncated flag
  reg [31:0] mem_data [0:DEPTH-1];
  reg mem_last [0:DEPTH-1];
  reg mem_trunc [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg out_valid;

  reg [7:0] release_lvl;
  reg [7:0] immed_lvl;
  reg [7:0] aligned_lvl;
  reg [2:0] event_filter;
  reg sticky_ovf;
  reg ovf_state;
  reg in_frame;
  reg frame_accept;
  reg frame_stored;
  reg frame_cut;
  reg [15:0] frame_id;
  reg last_pending;

  wire [7:0] whole_pct;
  wire [7:0] half_pct;

  fill_percent #(
    .AW(AW)
  ) u_pct (
    .count(count),
    .whole_pct(whole_pct),
    .half_pct(half_pct)
  );

  wire full;
  wire immed_hit;
  wire aligned_hit;
  wire release_hit;
  assign full = count[AW];
  assign immed_hit = half_pct > immed_lvl;
  assign aligned_hit = half_pct > aligned_lvl;
  assign release_hit = half_pct < release_lvl;

  // the stream is never stalled: overflow drops data instead of pushing back
  assign cam_ready = 1'b1;

  wire storing;
  assign storing = in_frame && frame_accept;
  wire cut_now;
  assign cut_now = storing && !frame_cut && (immed_hit || full);
  wire push_data;
  assign push_data = storing && !frame_cut && !cut_now && cam_valid
    && !full;
  // a truncated frame still needs a closing word for the dma
  wire push_close;
  assign push_close = last_pending && !full && !push_data;
  wire push;
  assign push = push_data || push_close;

  wire pop;
  assign pop = out_valid && dma_ready;
  wire mem_has;
  assign mem_has = (count != {(AW+1){1'b0}});
  wire load_out;
  assign load_out = mem_has && (!out_valid || dma_ready);
  assign dma_valid = out_valid;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      dma_data <= 32'h0000_0000;
      dma_last <= 1'b0;
      dma_truncated <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load_out) begin
        rd_ptr <= rd_ptr + 1'b1;
        dma_data <= mem_data[rd_ptr];
        dma_last <= mem_last[rd_ptr];
        dma_truncated <= mem_trunc[rd_ptr];
        out_valid <= 1'b1;
      end else if (pop) begin
        out_valid <= 1'b0;
      end
      if (push && !load_out) begin
        count <= count + 1'b1;
      end else if (!push && load_out) begin
        count <= count - 1'b1;
      end
    end
  end

  // storage has no reset: contents matter only behind the pointers
  always @(posedge pclk) begin
    if (push) begin
      mem_data[wr_ptr] <= push_data ? cam_data : 32'h0000_0000;
      mem_last[wr_ptr] <= push_close || cam_eof;
      mem_trunc[wr_ptr] <= push_close;
    end
  end

  // frame tracking and overflow state
  reg next_ovf_state;
  always @* begin
    next_ovf_state = ovf_state;
    if (cut_now) begin
      next_ovf_state = 1'b1;
    end else if (ovf_state && release_hit) begin
      next_ovf_state = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_state <= 1'b0;
      in_frame <= 1'b0;
      frame_accept <= 1'b0;
      frame_stored <= 1'b0;
      frame_cut <= 1'b0;
      frame_id <= 16'h0000;
      last_pending <= 1'b0;
    end else begin
      ovf_state <= next_ovf_state;
      if (push_close) begin
        last_pending <= 1'b0;
      end
      if (cut_now) begin
        frame_cut <= 1'b1;
        if (frame_stored) begin
          last_pending <= 1'b1;
        end
      end
      if (push_data) begin
        frame_stored <= 1'b1;
      end
      if (cam_sof) begin
        in_frame <= 1'b1;
        frame_id <= cam_frame_id;
        frame_stored <= 1'b0;
        frame_cut <= 1'b0;
        // aligned threshold only looked at between frames; no hysteresis
        frame_accept <= !next_ovf_state && !aligned_hit;
      end
      if (cam_eof) begin
        in_frame <= 1'b0;
      end
    end
  end

  // classification at end of frame
  wire [2:0] frame_class;
  wire eof_stored;
  assign eof_stored = frame_stored || push_data;
  assign frame_class[`MASK_DROP_BIT] = !eof_stored;
  assign frame_class[`MASK_TRUNC_BIT] = eof_stored
    && (frame_cut || cut_now);
  assign frame_class[`MASK_GOOD_BIT] = eof_stored && !frame_cut
    && !cut_now;
  wire [2:0] class_sel;
  assign class_sel[`FILT_TRUNC_BIT] = frame_class[`MASK_TRUNC_BIT];
  assign class_sel[`FILT_DROP_BIT] = frame_class[`MASK_DROP_BIT];
  assign class_sel[`FILT_GOOD_BIT] = frame_class[`MASK_GOOD_BIT];
  wire report;
  // filter bits select classes: codes 1..7 cover all unions
  assign report = |(class_sel & event_filter);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_valid <= 1'b0;
      event_record <= 64'h0000_0000_0000_0000;
    end else begin
      event_valid <= 1'b0;
      if (in_frame && cam_eof && report) begin
        event_valid <= 1'b1;
        event_record <= 64'h0000_0000_0000_0000;
        event_record[`REC_ID_MSB:`REC_ID_LSB] <= frame_id;
        event_record[`REC_MASK_MSB:`REC_MASK_LSB] <=
          {13'h0000, frame_class};
      end
    end
  end

  // apb slave, zero wait states
  assign pready = 1'b1;
  wire access;
  assign access = psel && penable;
  reg known;
  always @* begin
    known = 1'b0;
    if (paddr == `ADDR_OCCUPANCY) begin
      known = 1'b1;
    end else if (paddr == `ADDR_STICKY_OVF) begin
      known = 1'b1;
    end else if (paddr == `ADDR_RELEASE_LVL) begin
      known = 1'b1;
    end else if (paddr == `ADDR_IMMED_LVL) begin
      known = 1'b1;
    end else if (paddr == `ADDR_ALIGNED_LVL) begin
      known = 1'b1;
    end else if (paddr == `ADDR_EVENT_FILTER) begin
      known = 1'b1;
    end else if (paddr == `ADDR_STATE) begin
      known = 1'b1;
    end
  end
  assign pslverr = access && !known;
  wire wr_ok;
  assign wr_ok = access && pwrite;
  wire rd_sticky;
  assign rd_sticky = access && !pwrite && (paddr == `ADDR_STICKY_OVF);
  // overflow covers the threshold state, a full buffer and a frame
  // refused at its start by the frame-aligned level
  wire aligned_drop;
  assign aligned_drop = cam_sof && aligned_hit;
  wire ovf_event;
  assign ovf_event = next_ovf_state || full || aligned_drop;

  // threshold writes whose low byte is above 100.0 percent are clamped to the top
  wire [7:0] wlvl;
  assign wlvl = (pwdata[7:0] > `HALF_PCT_MAX) ? `HALF_PCT_MAX : pwdata[7:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      release_lvl <= `RST_RELEASE_LVL;
      immed_lvl <= `RST_IMMED_LVL;
      aligned_lvl <= `RST_ALIGNED_LVL;
      event_filter <= `RST_EVENT_FILTER;
      sticky_ovf <= 1'b0;
    end else begin
      if (ovf_event) begin
        sticky_ovf <= 1'b1;
      // only a one that the reader was shown is cleared
      end else if (rd_sticky && prdata[0]) begin
        sticky_ovf <= 1'b0;
      end
      if (wr_ok) begin
        if (paddr == `ADDR_RELEASE_LVL) begin
          release_lvl <= wlvl;
        end else if (paddr == `ADDR_IMMED_LVL) begin
          immed_lvl <= wlvl;
        end else if (paddr == `ADDR_ALIGNED_LVL) begin
          aligned_lvl <= wlvl;
        end else if (paddr == `ADDR_EVENT_FILTER) begin
          event_filter <= pwdata[2:0];
        end
      end
    end
  end

  // read data is captured in setup and stands through the access phase
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h0000_0000;
    if (paddr == `ADDR_OCCUPANCY) begin
      next_prdata = {24'h000000, whole_pct};
    end else if (paddr == `ADDR_STICKY_OVF) begin
      next_prdata = {31'h00000000, sticky_ovf};
    end else if (paddr == `ADDR_RELEASE_LVL) begin
      next_prdata = {24'h000000, release_lvl};
    end else if (paddr == `ADDR_IMMED_LVL) begin
      next_prdata = {24'h000000, immed_lvl};
    end else if (paddr == `ADDR_ALIGNED_LVL) begin
      next_prdata = {24'h000000, aligned_lvl};
    end else if (paddr == `ADDR_EVENT_FILTER) begin
      next_prdata = {29'h00000000, event_filter};
    end else if (paddr == `ADDR_STATE) begin
      next_prdata = {29'h00000000, full, frame_accept, ovf_state};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end
endmodule // frame_buffer_overflow_ctrl

`default_nettype wire

// ===== test/fbo_assertions.sv
/* port checker for the overflow supervisor.
 assumes bind onto frame_buffer_overflow_ctrl, one clock. */
`timescale 1ns/1ps
`default_nettype none
module fbo_assertions (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire cam_sof,
  input wire cam_eof,
  input wire [15:0] cam_frame_id,
  input wire [31:0] dma_data,
  input wire dma_valid,
  input wire dma_truncated,
  input wire dma_last,
  input wire event_valid,
  input wire [63:0] event_record
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [2:0] filt;
  reg [15:0] id;
  wire rd = psel && penable && !pwrite;
  wire [2:0] cls = event_record[34:32];
  // snooped copies, so no internal probes are needed
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      filt <= 3'h3;
      id <= 16'h0;
    end else begin
      if (psel && penable && pwrite && paddr == 12'h014) filt <= pwdata[2:0];
      if (cam_sof) id <= cam_frame_id;
    end
  sequence s_ev_late; !cam_eof ##1 event_valid; endsequence
  sequence s_cut; dma_valid && dma_truncated; endsequence
  AST_PCT: assert property (
    rd && paddr == 12'h000 |-> prdata <= 32'd100)
    else $error("fill level above full");
  AST_STICKY: assert property (
    rd && paddr == 12'h004 |-> prdata[31:1] == 31'h0)
    else $error("sticky value wider than one bit");
  AST_EV_TIME: assert property (
    not s_ev_late) else $error("event not after frame end");
  AST_ID: assert property (
    event_valid |-> event_record[15:0] == id)
    else $error("event id differs from stream id");
  AST_FILT: assert property (
    event_valid |-> |(cls & filt)) else $error("event not selected");
  AST_CLASS: assert property (
    event_valid |-> $onehot(cls)) else $error("event class not unique");
  AST_RSVD: assert property (
    event_valid |-> event_record[31:16] == 16'h0 &&
    event_record[63:35] == 29'h0) else $error("reserved bits set");
  AST_CUT: assert property (
    s_cut |-> dma_last && dma_data == 32'h0)
    else $error("truncation marker malformed");
endmodule // fbo_assertions
bind frame_buffer_overflow_ctrl fbo_assertions fbo_assertions_i (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .cam_sof,
  .cam_eof, .cam_frame_id, .dma_data, .dma_valid, .dma_truncated,
  .dma_last, .event_valid, .event_record);
`default_nettype wire

// ===== test/cam_dma_model.sv
/* camera source and dma sink facing the supervisor.
 assumes shared pclk; the bench calls send and drives stall. */
`timescale 1ns/1ps
`default_nettype none
module cam_dma_model (
  input wire pclk,
  input wire stall,
  output logic cam_sof = 1'b0,
  output logic cam_eof = 1'b0,
  output logic [15:0] cam_frame_id = 16'h0,
  output logic cam_valid = 1'b0,
  output logic [31:0] cam_data = 32'h0,
  output logic dma_ready,
  input wire dma_valid,
  input wire dma_last,
  input wire dma_truncated
);
  int cuts = 0;
  assign dma_ready = !stall;
  always @(posedge pclk)
    if (dma_valid && dma_ready && dma_last && dma_truncated) cuts <= cuts + 1;
  task send(input logic [15:0] id, input int n);
    @(posedge pclk);
    cam_sof <= 1'b1;
    cam_frame_id <= id;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      cam_sof <= 1'b0;
      // id means nothing outside sof
      cam_frame_id <= ~id;
      cam_valid <= 1'b1;
      cam_data <= {id, i[15:0]};
      cam_eof <= (i == n - 1);
    end
    @(posedge pclk);
    cam_valid <= 1'b0;
    cam_eof <= 1'b0;
    cam_data <= ~cam_data;
  endtask
endmodule // cam_dma_model
`default_nettype wire

// ===== test/frame_buffer_overflow_ctrl_bench.sv
/* self-checking bench for the overflow supervisor.
 assumes the bound checker and the camera/dma model are compiled. */
`timescale 1ns/1ps
`default_nettype none
module frame_buffer_overflow_ctrl_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic stall = 0, pready, pslverr, perr, cam_sof, cam_eof, cam_valid;
  logic cam_ready, dma_valid, dma_last, dma_truncated, dma_ready;
  logic event_valid;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, cam_data, dma_data, rdat;
  logic [15:0] cam_frame_id;
  logic [63:0] event_record, ev_rec;
  int fails = 0, comparisons = 0, ev_n = 0;
  logic dma_head = 1'b1;
  logic [31:0] dma_first = 32'h0;
  always #4 pclk = ~pclk;
  frame_buffer_overflow_ctrl frame_buffer_overflow_ctrl_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cam_sof, .cam_eof, .cam_frame_id, .cam_valid, .cam_data, .cam_ready,
    .dma_valid, .dma_data, .dma_last, .dma_truncated, .dma_ready,
    .event_valid, .event_record);
  cam_dma_model cam_dma_model_i (.pclk, .stall, .cam_sof, .cam_eof,
    .cam_frame_id, .cam_valid, .cam_data, .dma_ready, .dma_valid,
    .dma_last, .dma_truncated);
  always @(posedge pclk)
    if (event_valid === 1'b1) begin
      ev_n <= ev_n + 1;
      ev_rec <= event_record;
    end
  // first word of every frame handed to the dma
  always @(posedge pclk)
    if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
      if (dma_head) dma_first <= dma_data;
      dma_head <= dma_last;
    end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rdat, e);
  endtask
  task frame(input logic [15:0] id, input int n, input logic [15:0] mask);
    int n0;
    n0 = ev_n;
    cam_dma_model_i.send(id, n);
    repeat (3) @(posedge pclk);
    chk(ev_n - n0, 1);
    chk(ev_rec[47:32], mask);
    chk(ev_rec[15:0], id);
  endtask
  task t_reset;
    rd(12'h008, 32'd100);
    rd(12'h00c, 32'd199);
    rd(12'h010, 32'd160);
    rd(12'h014, 32'd3);
    rd(12'h004, 32'd0);
    apb(12'h000, 1'b1, 32'h55);
    rd(12'h000, 32'd0);
    apb(12'h100, 1'b0, 32'h0);
    chk(perr, 1'b1);
    apb(12'h008, 1'b1, 32'd201);
    rd(12'h008, 32'd200);
    chk(cam_ready, 1'b1);
    $display("t_reset done");
  endtask
  task t_filter;
    int n0;
    for (int f = 0; f < 8; f++) begin
      apb(12'h014, 1'b1, 32'(f));
      n0 = ev_n;
      cam_dma_model_i.send(16'hfff8 + f[15:0], 2);
      repeat (3) @(posedge pclk);
      chk(ev_n - n0, f[2]);
    end
    chk(ev_rec, {16'h0, 16'h4, 16'h0, 16'hffff});
    $display("t_filter done");
  endtask
  task t_trunc;
    apb(12'h008, 1'b1, 32'd10);
    apb(12'h00c, 1'b1, 32'd20);
    stall <= 1'b1;
    frame(16'h0010, 150, 16'h1);
    rd(12'h000, 32'd10);
    frame(16'h0011, 4, 16'h2);
    rd(12'h004, 32'd1);
    rd(12'h018, 32'd1);
    stall <= 1'b0;
    wait (cam_dma_model_i.cuts == 1);
    repeat (3) @(posedge pclk);
    rd(12'h004, 32'd1);
    rd(12'h004, 32'd0);
    rd(12'h000, 32'd0);
    frame(16'h0012, 4, 16'h4);
    rd(12'h018, 32'd2);
    $display("t_trunc done");
  endtask
  task t_aligned;
    apb(12'h00c, 1'b1, 32'd199);
    apb(12'h010, 1'b1, 32'd4);
    stall <= 1'b1;
    frame(16'h0020, 40, 16'h4);
    frame(16'h0021, 4, 16'h2);
    rd(12'h004, 32'd1);
    stall <= 1'b0;
    wait (dma_valid === 1'b0);
    repeat (3) @(posedge pclk);
    frame(16'h0022, 4, 16'h4);
    chk(dma_first, {16'h0022, 16'h0000});
    $display("t_aligned done");
  endtask
  task end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_filter;
    t_trunc;
    t_aligned;
    end_sim;
  end
  // far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    end_sim;
  end
endmodule // frame_buffer_overflow_ctrl_bench
`default_nettype wire
